/* File: design/cis_core.v */
// Single-cycle execute stage of a 16-bit core with its multiply-accumulate unit.
`include "cis_defs.vh"

module cis_core (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        instr_valid,
    input  wire [15:0] instr_w0,
    input  wire [15:0] instr_w1,
    input  wire [15:0] opa,
    input  wire [15:0] opb,
    input  wire        bit_dst,
    input  wire        bit_src,
    input  wire [15:0] pc_next,
    output reg         done_q,
    output reg         len4_q,
    output reg         illegal_q,
    output reg  [3:0]  dst_q,
    output reg  [15:0] res_q,
    output reg         res_we_q,
    output reg  [31:0] muldiv_q,
    output reg         bit_q,
    output reg         bit_we_q,
    output reg         jump_q,
    output reg  [15:0] target_q,
    output reg         call_q,
    output reg         push_q,
    output reg  [15:0] push_data_q,
    output reg         pop_q,
    output reg  [1:0]  ret_q,
    output reg         trap_q,
    output reg  [6:0]  trap_num_q,
    output reg         ext_q,
    output reg         ext_seg_q,
    output reg         ext_reg_q,
    output reg  [15:0] ext_val_q,
    output reg  [1:0]  ext_cnt_q,
    output reg  [31:0] acc_q,
    output reg         flag_z_q,
    output reg         flag_n_q,
    output reg         flag_c_q,
    output reg         flag_v_q
);

    // Division is combinational; it dominates timing but keeps one instruction per cycle.
    wire [15:0] dq_s = $signed(muldiv_q[15:0]) / $signed(opb);
    wire [15:0] dr_s = $signed(muldiv_q[15:0]) % $signed(opb);
    wire [15:0] dq_u = muldiv_q[15:0] / opb;
    wire [15:0] dr_u = muldiv_q[15:0] % opb;
    wire [31:0] lq_s = $signed(muldiv_q) / $signed(opb);
    wire [31:0] lr_s = $signed(muldiv_q) % $signed(opb);
    wire [31:0] lq_u = muldiv_q / opb;
    wire [31:0] lr_u = muldiv_q % opb;
    wire [31:0] pr_s = $signed(opa) * $signed(opb);
    wire [31:0] pr_u = opa * opb;
    wire [4:0]  csh  = instr_w1[`CIS_CO_SH_HI:`CIS_CO_SH_LO];

    reg [5:0]  fn;
    reg        len4;
    reg        byt;
    reg        cin;
    reg        upd;
    reg        cmpf;
    reg        unk;
    reg [1:0]  fixlen;
    reg [15:0] src;
    reg [15:0] aw;
    reg [15:0] bw;
    reg [15:0] r;
    reg [15:0] fr;
    reg [15:0] tgt;
    reg [16:0] sum;
    reg [16:0] dif;
    reg [31:0] cop;
    reg [31:0] cdif;
    reg [31:0] rot;
    reg [31:0] n_md;
    reg [31:0] n_acc;
    reg        n_we;
    reg        n_bit;
    reg        n_bitwe;
    reg        n_jmp;
    reg        n_call;
    reg        n_push;
    reg        n_pop;
    reg [1:0]  n_ret;
    reg        n_trap;
    reg        n_ext;
    reg        n_z;
    reg        n_n;
    reg        n_c;
    reg        n_v;
    reg        n_ill;

    function cond_ok;
        input [3:0] cc;
        begin
            case (cc)
                4'h0:    cond_ok = 1'b1;
                4'h1:    cond_ok = flag_z_q;
                4'h2:    cond_ok = ~flag_z_q;
                4'h3:    cond_ok = flag_c_q;
                4'h4:    cond_ok = ~flag_c_q;
                4'h5:    cond_ok = flag_n_q;
                4'h6:    cond_ok = ~flag_n_q;
                4'h7:    cond_ok = flag_v_q;
                default: cond_ok = 1'b0;
            endcase
        end
    endfunction

    // An all-zero word needs no shift and reports zero.
    function [4:0] norm_count;
        input [15:0] v;
        integer i;
        reg     hit;
        begin
            norm_count = 5'h00;
            hit = 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                if (v[i])
                    hit = 1'b1;
                else if (!hit)
                    norm_count = norm_count + 5'h01;
            end
            if (!hit)
                norm_count = 5'h00;
        end
    endfunction

    always @* begin
        len4 = instr_w0[`CIS_LEN_BIT];
        byt  = instr_w0[`CIS_BYTE_BIT];
        fn   = instr_w0[`CIS_FN_HI:`CIS_FN_LO];
        src  = len4 ? instr_w1 : opb;
        aw   = byt ? {8'h00, opa[7:0]} : opa;
        bw   = byt ? {8'h00, src[7:0]} : src;
        cin  = ((fn == `CF_ADDC) || (fn == `CF_SUBC)) & flag_c_q;
        sum  = {1'b0, aw} + {1'b0, bw} + {16'h0000, cin};
        dif  = {1'b0, aw} - {1'b0, bw} - {16'h0000, cin};
        cop  = {opa, opb};
        cdif = acc_q - cop;
        // Rotates shift a doubled copy; only the low half is the result.
        rot  = {opa, opa} >> ((fn == `CF_ROL) ? (5'h10 - {1'b0, opb[3:0]}) : {1'b0, opb[3:0]});
        case (instr_w0[`CIS_JM_HI:`CIS_JM_LO])
            `CIS_JM_IND: tgt = opb;
            `CIS_JM_REL: tgt = pc_next + instr_w1;
            default:     tgt = instr_w1;
        endcase
        fixlen  = `CIS_LEN_ANY;
        unk     = 1'b0;
        upd     = 1'b0;
        cmpf    = 1'b0;
        r       = 16'h0000;
        fr      = 16'h0000;
        n_md    = muldiv_q;
        n_acc   = acc_q;
        n_we    = 1'b0;
        n_bit   = 1'b0;
        n_bitwe = 1'b0;
        n_jmp   = 1'b0;
        n_call  = 1'b0;
        n_push  = 1'b0;
        n_pop   = 1'b0;
        n_ret   = 2'h0;
        n_trap  = 1'b0;
        n_ext   = 1'b0;
        n_z     = flag_z_q;
        n_n     = flag_n_q;
        n_c     = flag_c_q;
        n_v     = flag_v_q;
        case (fn)
            `CF_NOP: fixlen = `CIS_LEN_2;
            `CF_ADD, `CF_ADDC: begin
                r    = sum[15:0];
                n_c  = byt ? sum[8] : sum[16];
                upd  = 1'b1;
                n_we = 1'b1;
            end
            `CF_SUB, `CF_SUBC, `CF_CMP: begin
                r    = dif[15:0];
                n_c  = byt ? dif[8] : dif[16];
                upd  = 1'b1;
                n_we = (fn != `CF_CMP);
            end
            `CF_AND, `CF_OR, `CF_XOR, `CF_MOV: begin
                if (fn == `CF_AND)
                    r = aw & bw;
                else if (fn == `CF_OR)
                    r = aw | bw;
                else if (fn == `CF_XOR)
                    r = aw ^ bw;
                else
                    r = bw;
                upd  = 1'b1;
                n_we = 1'b1;
            end
            `CF_MUL, `CF_MULU: begin
                fixlen = `CIS_LEN_2;
                n_md   = (fn == `CF_MUL) ? pr_s : pr_u;
            end
            `CF_DIV, `CF_DIVU, `CF_LDIV, `CF_LDIVU: begin
                fixlen = `CIS_LEN_2;
                n_v    = (opb == 16'h0000);
                // A zero divisor leaves the muldiv register untouched.
                if (opb == 16'h0000)
                    n_md = muldiv_q;
                else if (fn == `CF_DIV)
                    n_md = {dr_s, dq_s};
                else if (fn == `CF_DIVU)
                    n_md = {dr_u, dq_u};
                else if (fn == `CF_LDIV)
                    n_md = {lr_s[15:0], lq_s[15:0]};
                else
                    n_md = {lr_u[15:0], lq_u[15:0]};
            end
            `CF_NOT, `CF_NEG: begin
                fixlen = `CIS_LEN_2;
                r      = (fn == `CF_NOT) ? ~aw : 16'h0000 - aw;
                upd    = 1'b1;
                n_we   = 1'b1;
            end
            `CF_SHL, `CF_SHR, `CF_ROL, `CF_ROR, `CF_SAR: begin
                fixlen = `CIS_LEN_2;
                case (fn)
                    `CF_SHL: r = opa << opb[3:0];
                    `CF_SHR: r = opa >> opb[3:0];
                    `CF_ROL: r = rot[15:0];
                    `CF_ROR: r = rot[15:0];
                    default: r = $signed(opa) >>> opb[3:0];
                endcase
                upd  = 1'b1;
                n_we = 1'b1;
            end
            `CF_NORM: begin
                fixlen = `CIS_LEN_2;
                r      = {11'h000, norm_count(opb)};
                upd    = 1'b1;
                n_we   = 1'b1;
            end
            `CF_EXT_SIGN, `CF_EXT_ZERO: begin
                r = {(fn == `CF_EXT_SIGN) ? {8{src[7]}} : 8'h00, src[7:0]};
                upd  = 1'b1;
                n_we = 1'b1;
            end
            `CF_CMP_DEC1, `CF_CMP_DEC2, `CF_CMP_INC1, `CF_CMP_INC2: begin
                fr   = dif[15:0];
                n_c  = dif[16];
                cmpf = 1'b1;
                upd  = 1'b1;
                case (fn)
                    `CF_CMP_DEC1: r = opa - 16'h0001;
                    `CF_CMP_DEC2: r = opa - 16'h0002;
                    `CF_CMP_INC1: r = opa + 16'h0001;
                    default:      r = opa + 16'h0002;
                endcase
                n_we = 1'b1;
            end
            `CF_BIT_COPY, `CF_BIT_COPYN, `CF_BIT_AND, `CF_BIT_OR, `CF_BIT_XOR, `CF_BIT_CMP: begin
                fixlen = `CIS_LEN_4;
                case (fn)
                    `CF_BIT_COPY:  n_bit = bit_src;
                    `CF_BIT_COPYN: n_bit = ~bit_src;
                    `CF_BIT_AND:   n_bit = bit_dst & bit_src;
                    `CF_BIT_OR:    n_bit = bit_dst | bit_src;
                    default:       n_bit = bit_dst ^ bit_src;
                endcase
                // Compare only reports equality in the zero flag.
                n_bitwe = (fn != `CF_BIT_CMP);
                n_z     = (fn == `CF_BIT_CMP) ? (bit_dst == bit_src) : ~n_bit;
            end
            `CF_BFMOD_LO: begin
                fixlen = `CIS_LEN_4;
                r = (opa & ~{8'h00, instr_w1[15:8]}) | {8'h00, instr_w1[7:0] & instr_w1[15:8]};
                n_we = 1'b1;
            end
            `CF_BFMOD_HI: begin
                fixlen = `CIS_LEN_4;
                r = (opa & ~{instr_w1[15:8], 8'h00}) | {instr_w1[7:0] & instr_w1[15:8], 8'h00};
                n_we = 1'b1;
            end
            `CF_JUMP, `CF_CALL: begin
                fixlen = `CIS_LEN_4;
                n_jmp  = cond_ok(instr_w0[`CIS_CC_HI:`CIS_CC_LO]);
                n_call = n_jmp & (fn == `CF_CALL);
            end
            `CF_BR_SET, `CF_BR_SET_CLR, `CF_BR_CLR, `CF_BR_CLR_SET: begin
                fixlen = `CIS_LEN_4;
                tgt    = pc_next + instr_w1;
                if ((fn == `CF_BR_SET) || (fn == `CF_BR_SET_CLR))
                    n_jmp = bit_dst;
                else
                    n_jmp = ~bit_dst;
                // The bit only toggles when the branch is taken.
                n_bitwe = n_jmp & ((fn == `CF_BR_SET_CLR) || (fn == `CF_BR_CLR_SET));
                n_bit   = (fn == `CF_BR_CLR_SET);
            end
            `CF_PUSH_CALL: begin
                fixlen = `CIS_LEN_4;
                n_push = 1'b1;
                n_call = 1'b1;
                n_jmp  = 1'b1;
                tgt    = instr_w1;
            end
            `CF_CTX_PUSH: begin
                fixlen = `CIS_LEN_4;
                n_push = 1'b1;
                r      = src;
                n_we   = 1'b1;
            end
            `CF_TRAP: begin
                fixlen = `CIS_LEN_2;
                n_trap = 1'b1;
            end
            `CF_RET, `CF_RET_POP: begin
                fixlen = `CIS_LEN_2;
                n_ret  = `CIS_RET_NEAR;
                n_pop  = (fn == `CF_RET_POP);
            end
            `CF_RET_FAR: begin
                fixlen = `CIS_LEN_2;
                n_ret  = `CIS_RET_FAR;
            end
            `CF_RET_INT: begin
                fixlen = `CIS_LEN_2;
                n_ret  = `CIS_RET_INT;
            end
            `CF_PWR_LEGACY: fixlen = `CIS_LEN_4;
            `CF_XPAGE, `CF_XPAGE_REG, `CF_XSEG, `CF_XSEG_REG: n_ext = 1'b1;
            `CF_COPROC: begin
                fixlen = `CIS_LEN_4;
                case (instr_w1[`CIS_CO_HI:`CIS_CO_LO])
                    `CC_MUL:  n_acc = pr_s;
                    `CC_MAC:  n_acc = acc_q + pr_s;
                    `CC_ADD:  n_acc = acc_q + cop;
                    `CC_SUB:  n_acc = cdif;
                    `CC_SHR:  n_acc = acc_q >> csh;
                    `CC_SAR:  n_acc = $signed(acc_q) >>> csh;
                    `CC_SHL:  n_acc = acc_q << csh;
                    `CC_LOAD: n_acc = cop;
                    `CC_STORE: begin
                        r    = acc_q[31:16];
                        n_we = 1'b1;
                    end
                    `CC_CMP: begin
                        n_z = (cdif == 32'h0000_0000);
                        n_n = cdif[31];
                    end
                    `CC_MAX: if ($signed(cop) > $signed(acc_q)) n_acc = cop;
                    `CC_MIN: if ($signed(cop) < $signed(acc_q)) n_acc = cop;
                    `CC_ABS: if (acc_q[31]) n_acc = 32'h0000_0000 - acc_q;
                    `CC_RND: n_acc = (acc_q + `CIS_RND_HALF) & `CIS_RND_MASK;
                    `CC_MOV: begin
                        r    = opb;
                        n_we = 1'b1;
                    end
                    default: if (!instr_w1[`CIS_CO_NOP_BIT]) n_acc = 32'h0000_0000 - acc_q;
                endcase
            end
            default: unk = 1'b1;
        endcase
        if (upd) begin
            if (!cmpf)
                fr = r;
            n_z = byt ? (fr[7:0] == 8'h00) : (fr == 16'h0000);
            n_n = byt ? fr[7] : fr[15];
        end
        n_ill = unk | ((fixlen == `CIS_LEN_2) & len4) | ((fixlen == `CIS_LEN_4) & ~len4);
    end

    wire go = instr_valid & ~n_ill;

    always @(posedge clk) begin
        if (sys_rst) begin
            done_q      <= 1'b0;
            len4_q      <= 1'b0;
            illegal_q   <= 1'b0;
            dst_q       <= 4'h0;
            res_q       <= 16'h0000;
            res_we_q    <= 1'b0;
            muldiv_q    <= 32'h0000_0000;
            bit_q       <= 1'b0;
            bit_we_q    <= 1'b0;
            jump_q      <= 1'b0;
            target_q    <= 16'h0000;
            call_q      <= 1'b0;
            push_q      <= 1'b0;
            push_data_q <= 16'h0000;
            pop_q       <= 1'b0;
            ret_q       <= 2'h0;
            trap_q      <= 1'b0;
            trap_num_q  <= 7'h00;
            ext_q       <= 1'b0;
            ext_seg_q   <= 1'b0;
            ext_reg_q   <= 1'b0;
            ext_val_q   <= 16'h0000;
            ext_cnt_q   <= 2'h0;
            acc_q       <= 32'h0000_0000;
            flag_z_q    <= 1'b0;
            flag_n_q    <= 1'b0;
            flag_c_q    <= 1'b0;
            flag_v_q    <= 1'b0;
        end else begin
            done_q    <= instr_valid;
            illegal_q <= instr_valid & n_ill;
            res_we_q  <= go & n_we;
            bit_we_q  <= go & n_bitwe;
            jump_q    <= go & n_jmp;
            call_q    <= go & n_call;
            push_q    <= go & n_push;
            pop_q     <= go & n_pop;
            ret_q     <= go ? n_ret : 2'h0;
            trap_q    <= go & n_trap;
            ext_q     <= go & n_ext;
            if (instr_valid)
                len4_q <= len4;
            if (go) begin
                dst_q       <= instr_w0[`CIS_DST_HI:`CIS_DST_LO];
                res_q       <= byt ? {opa[15:8], r[7:0]} : r;
                muldiv_q    <= n_md;
                bit_q       <= n_bit;
                target_q    <= tgt;
                push_data_q <= opa;
                trap_num_q  <= instr_w0[`CIS_TRAP_HI:0];
                ext_seg_q   <= (fn == `CF_XSEG) || (fn == `CF_XSEG_REG);
                ext_reg_q   <= (fn == `CF_XPAGE_REG) || (fn == `CF_XSEG_REG);
                ext_val_q   <= src;
                ext_cnt_q   <= instr_w0[`CIS_JM_HI:`CIS_JM_LO];
                acc_q       <= n_acc;
                flag_z_q    <= n_z;
                flag_n_q    <= n_n;
                flag_c_q    <= n_c;
                flag_v_q    <= n_v;
            end
        end
    end

endmodule // cis_core

/* File: design/cis_defs.vh */
// Field positions, function codes and constants of the instruction execute unit.
`ifndef CIS_DEFS_VH
`define CIS_DEFS_VH
`define CIS_LEN_BIT    15
`define CIS_BYTE_BIT   14
`define CIS_FN_HI      13
`define CIS_FN_LO      8
`define CIS_DST_HI     7
`define CIS_DST_LO     4
`define CIS_CC_HI      3
`define CIS_CC_LO      0
`define CIS_JM_HI      5
`define CIS_JM_LO      4
`define CIS_TRAP_HI    6
`define CIS_CO_HI      3
`define CIS_CO_LO      0
`define CIS_CO_SH_HI   8
`define CIS_CO_SH_LO   4
`define CIS_CO_NOP_BIT 15
`define CIS_LEN_ANY    2'h0
`define CIS_LEN_2      2'h1
`define CIS_LEN_4      2'h2
`define CIS_JM_IND     2'h1
`define CIS_JM_REL     2'h2
`define CIS_RET_NEAR   2'h1
`define CIS_RET_FAR    2'h2
`define CIS_RET_INT    2'h3
`define CIS_RND_HALF   32'h0000_8000
`define CIS_RND_MASK   32'hffff_0000
`define CF_NOP         6'h00
`define CF_ADD         6'h01
`define CF_ADDC        6'h02
`define CF_SUB         6'h03
`define CF_SUBC        6'h04
`define CF_AND         6'h05
`define CF_OR          6'h06
`define CF_XOR         6'h07
`define CF_CMP         6'h08
`define CF_MOV         6'h09
`define CF_MUL         6'h0a
`define CF_MULU        6'h0b
`define CF_DIV         6'h0c
`define CF_DIVU        6'h0d
`define CF_LDIV        6'h0e
`define CF_LDIVU       6'h0f
`define CF_NOT         6'h10
`define CF_NEG         6'h11
`define CF_SHL         6'h12
`define CF_SHR         6'h13
`define CF_ROL         6'h14
`define CF_ROR         6'h15
`define CF_SAR         6'h16
`define CF_NORM        6'h17
`define CF_EXT_SIGN    6'h18
`define CF_EXT_ZERO    6'h19
`define CF_CMP_DEC1    6'h1a
`define CF_CMP_DEC2    6'h1b
`define CF_CMP_INC1    6'h1c
`define CF_CMP_INC2    6'h1d
`define CF_BIT_COPY    6'h1e
`define CF_BIT_COPYN   6'h1f
`define CF_BIT_AND     6'h20
`define CF_BIT_OR      6'h21
`define CF_BIT_XOR     6'h22
`define CF_BIT_CMP     6'h23
`define CF_BFMOD_LO    6'h24
`define CF_BFMOD_HI    6'h25
`define CF_JUMP        6'h26
`define CF_CALL        6'h27
`define CF_BR_SET      6'h28
`define CF_BR_SET_CLR  6'h29
`define CF_BR_CLR      6'h2a
`define CF_BR_CLR_SET  6'h2b
`define CF_PUSH_CALL   6'h2c
`define CF_CTX_PUSH    6'h2d
`define CF_TRAP        6'h2e
`define CF_RET         6'h2f
`define CF_RET_POP     6'h30
`define CF_RET_FAR     6'h31
`define CF_RET_INT     6'h32
`define CF_PWR_LEGACY  6'h33
`define CF_XPAGE       6'h34
`define CF_XPAGE_REG   6'h35
`define CF_XSEG        6'h36
`define CF_XSEG_REG    6'h37
`define CF_COPROC      6'h38
`define CC_MUL         4'h0
`define CC_MAC         4'h1
`define CC_ADD         4'h2
`define CC_SUB         4'h3
`define CC_SHR         4'h4
`define CC_SAR         4'h5
`define CC_SHL         4'h6
`define CC_LOAD        4'h7
`define CC_STORE       4'h8
`define CC_CMP         4'h9
`define CC_MAX         4'ha
`define CC_MIN         4'hb
`define CC_ABS         4'hc
`define CC_RND         4'hd
`define CC_MOV         4'he
`endif

/* File: test/cis_core_props.sv */
// Port-level checker of the execute stage.
`include "cis_defs.vh"
module cis_core_props (
    input wire        clk,
    input wire        sys_rst,
    input wire        instr_valid,
    input wire [15:0] instr_w0,
    input wire [15:0] instr_w1,
    input wire [15:0] opa,
    input wire [15:0] opb,
    input wire [15:0] pc_next,
    input wire        done_q,
    input wire        illegal_q,
    input wire [3:0]  dst_q,
    input wire [15:0] res_q,
    input wire        res_we_q,
    input wire [31:0] muldiv_q,
    input wire        jump_q,
    input wire [15:0] target_q,
    input wire        trap_q,
    input wire [6:0]  trap_num_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [5:0] fn = instr_w0[13:8];
    wire       w2 = instr_valid && !instr_w0[15] && !instr_w0[14];
    a_done_latency: assert property (instr_valid |=> done_q)
        else $error("done missing after instruction");
    a_idle_quiet: assert property (!instr_valid |=> !done_q && !res_we_q)
        else $error("activity without instruction");
    a_add_sum: assert property (w2 && fn == `CF_ADD |=>
        res_we_q && res_q == 16'($past(opa) + $past(opb))) else $error("add result wrong");
    a_mul_signed: assert property (w2 && fn == `CF_MUL |=>
        $signed(muldiv_q) == $signed($past(opa)) * $signed($past(opb)))
        else $error("signed product wrong");
    a_cpl_inplace: assert property (w2 && fn == `CF_NOT |=>
        res_we_q && res_q == ~$past(opa) && dst_q == $past(instr_w0[7:4]))
        else $error("complement wrong");
    a_trap_number: assert property (w2 && fn == `CF_TRAP |=>
        trap_q && trap_num_q == $past(instr_w0[6:0])) else $error("trap number wrong");
    a_rel_jump: assert property (instr_valid && instr_w0 == {2'h2, `CF_JUMP, 8'h20} |=>
        jump_q && target_q == 16'($past(pc_next) + $past(instr_w1)))
        else $error("relative jump wrong");
    a_pwr_inert: assert property (instr_valid && instr_w0 == {2'h2, `CF_PWR_LEGACY, 8'h00} |=>
        done_q && !illegal_q && !res_we_q && !jump_q && !trap_q)
        else $error("legacy power op had an effect");
endmodule // cis_core_props
bind cis_core cis_core_props u_props (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_w0(instr_w0), .instr_w1(instr_w1), .opa(opa), .opb(opb), .pc_next(pc_next),
    .done_q(done_q), .illegal_q(illegal_q), .dst_q(dst_q), .res_q(res_q), .res_we_q(res_we_q),
    .muldiv_q(muldiv_q), .jump_q(jump_q), .target_q(target_q), .trap_q(trap_q),
    .trap_num_q(trap_num_q));

/* File: test/cis_regfile_model.sv */
// Register file model that feeds operands to the execute stage.
module cis_regfile_model (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire  [15:0] instr_w0,
    input  wire  [15:0] instr_w1,
    input  wire  [3:0]  dst_q,
    input  wire  [15:0] res_q,
    input  wire         res_we_q,
    output logic [15:0] opa,
    output logic [15:0] opb
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] regs [16];
    // Four-byte forms take the second operand from the stream, not the file.
    assign opa = regs[instr_w0[7:4]];
    assign opb = instr_w0[15] ? instr_w1 : regs[instr_w0[3:0]];
    always @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 16; i++) regs[i] <= 16'(i + 1);
        end else if (res_we_q) begin
            regs[dst_q] <= res_q;
        end
    end
endmodule // cis_regfile_model

/* File: test/tb_top.sv */
// Self-checking testbench of the execute stage.
`include "cis_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        instr_valid = 1'b0;
    logic [15:0] instr_w0 = 16'h0000;
    logic [15:0] instr_w1 = 16'h0000;
    logic [15:0] pc_next = 16'h0000;
    logic        bit_dst = 1'b0;
    logic        bit_src = 1'b0;
    wire  [15:0] opa, opb, res_q, target_q;
    wire  [31:0] muldiv_q, acc_q;
    wire  [6:0]  trap_num_q;
    wire  [3:0]  dst_q;
    wire  [1:0]  ret_q;
    wire         done_q, illegal_q, res_we_q, jump_q, call_q, trap_q, bit_q, bit_we_q, push_q;
    wire         ext_q, ext_seg_q, len4_q, flag_z_q, flag_v_q;
    int          n_errors = 0;
    int          checks = 0;
    always #50 clk = ~clk;
    cis_regfile_model u_rf (.clk(clk), .sys_rst(sys_rst), .instr_w0(instr_w0),
        .instr_w1(instr_w1), .dst_q(dst_q), .res_q(res_q), .res_we_q(res_we_q),
        .opa(opa), .opb(opb));
    cis_core dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_w0(instr_w0), .instr_w1(instr_w1), .opa(opa), .opb(opb), .bit_dst(bit_dst),
        .bit_src(bit_src), .pc_next(pc_next), .done_q(done_q), .len4_q(len4_q),
        .illegal_q(illegal_q), .dst_q(dst_q), .res_q(res_q), .res_we_q(res_we_q),
        .muldiv_q(muldiv_q), .bit_q(bit_q), .bit_we_q(bit_we_q), .jump_q(jump_q),
        .target_q(target_q), .call_q(call_q), .push_q(push_q), .push_data_q(), .pop_q(),
        .ret_q(ret_q), .trap_q(trap_q), .trap_num_q(trap_num_q), .ext_q(ext_q),
        .ext_seg_q(ext_seg_q), .ext_reg_q(), .ext_val_q(), .ext_cnt_q(), .acc_q(acc_q),
        .flag_z_q(flag_z_q), .flag_n_q(), .flag_c_q(), .flag_v_q(flag_v_q));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Valid stays up so callers can issue back to back; idle drops it.
    task automatic issue(input logic [15:0] w0, input logic [15:0] w1);
        instr_w0 = w0;
        instr_w1 = w1;
        instr_valid = 1'b1;
        @(posedge clk);
        #1;
    endtask
    task automatic idle();
        instr_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic t_alu();
        issue({2'h0, `CF_ADD, 8'h35}, 16'h0000);
        chk(res_q, 16'h000a);
        chk(dst_q, 4'h3);
        chk(res_we_q, 1'b1);
        idle();
        issue({2'h0, `CF_NOT, 8'h30}, 16'h0000);
        chk(res_q, 16'hfff5);
        idle();
    endtask
    task automatic t_muldiv();
        issue({2'h0, `CF_NEG, 8'h20}, 16'h0000);
        chk(res_q, 16'hfffd);
        idle();
        issue({2'h0, `CF_MUL, 8'h24}, 16'h0000);
        chk(muldiv_q, 32'hffff_fff1);
        issue({2'h0, `CF_MULU, 8'h24}, 16'h0000);
        chk(muldiv_q, 32'h0004_fff1);
        issue({2'h0, `CF_DIVU, 8'h44}, 16'h0000);
        chk(muldiv_q, 32'h0001_3330);
        idle();
    endtask
    task automatic t_flow();
        pc_next = 16'h1000;
        issue({2'h2, `CF_JUMP, 8'h20}, 16'h0040);
        chk({jump_q, target_q}, 17'h1_1040);
        issue({2'h2, `CF_JUMP, 8'h28}, 16'h0040);
        chk(jump_q, 1'b0);
        issue({2'h2, `CF_CALL, 8'h00}, 16'h2000);
        chk({call_q, target_q}, 17'h1_2000);
        issue({2'h0, `CF_TRAP, 8'h5a}, 16'h0000);
        chk({trap_q, trap_num_q}, 8'hda);
        issue({2'h0, `CF_RET_INT, 8'h00}, 16'h0000);
        chk(ret_q, 2'h3);
        idle();
    endtask
    task automatic t_legacy();
        issue({2'h2, `CF_PWR_LEGACY, 8'h00}, 16'h0000);
        chk({done_q, illegal_q, res_we_q, jump_q}, 4'h8);
        issue({2'h0, `CF_PWR_LEGACY, 8'h00}, 16'h0000);
        chk({done_q, illegal_q}, 2'h3);
        idle();
    endtask
    task automatic t_divide();
        issue({2'h0, `CF_LDIVU, 8'h44}, 16'h0000);
        chk(muldiv_q, 32'h0000_3d70);
        issue({2'h0, `CF_SUB, 8'h44}, 16'h0000);
        chk(flag_z_q, 1'b1);
        idle();
        issue({2'h0, `CF_DIVU, 8'h54}, 16'h0000);
        chk({flag_v_q, muldiv_q[15:0]}, 17'h1_3d70);
        issue({2'h0, `CF_NORM, 8'h51}, 16'h0000);
        chk(res_q, 16'h000e);
        issue({2'h0, `CF_ROL, 8'h31}, 16'h0000);
        chk(res_q, 16'hffd7);
        idle();
    endtask
    task automatic t_bits();
        bit_src = 1'b1;
        issue({2'h2, `CF_BIT_COPYN, 8'h00}, 16'h0000);
        chk({bit_we_q, bit_q}, 2'h2);
        issue({2'h2, `CF_BR_CLR_SET, 8'h00}, 16'h0010);
        chk({jump_q, bit_we_q, bit_q, target_q}, 19'h7_1010);
        bit_dst = 1'b1;
        issue({2'h2, `CF_BR_CLR_SET, 8'h00}, 16'h0010);
        chk({jump_q, bit_we_q}, 2'h0);
        issue({2'h2, `CF_PUSH_CALL, 8'h30}, 16'h3000);
        chk({push_q, call_q, target_q}, 18'h3_3000);
        issue({2'h0, `CF_XSEG, 8'h10}, 16'h0000);
        chk({ext_q, ext_seg_q}, 2'h3);
        issue({2'h2, `CF_COPROC, 8'h20}, {12'h000, `CC_LOAD});
        chk(acc_q, 32'hfffd_0007);
        chk(len4_q, 1'b1);
        issue({2'h2, `CF_COPROC, 8'h20}, {12'h000, `CC_RND});
        chk(acc_q, 32'hfffd_0000);
        idle();
    endtask
    task automatic t_reset(input int cycles);
        sys_rst = 1'b1;
        repeat (cycles) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        @(posedge clk);
        #1;
        chk(muldiv_q | acc_q, 32'h0000_0000);
        chk({done_q, res_we_q, jump_q, trap_q, ret_q}, 6'h00);
    endtask
    task automatic complete_run();
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        n_errors++;
        complete_run();
    end
    initial begin
        t_reset(20);
        t_alu();
        t_muldiv();
        t_flow();
        t_legacy();
        t_divide();
        t_bits();
        t_reset(1);
        complete_run();
    end
endmodule // tb_top
